/* dv/usd_core_checker.sv */
// Purpose: Port-level assertions for the serial channel core.
// Assumes: Status snapshot is taken at the setup edge, so $past gives its inputs.
// Notes: Attached by bind below the module.
`timescale 1ns/1ps
`include "usd_cfg.svh"

module usd_core_checker import usd_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire usd_pkg::usd_apb_req_t apb_in,
  input wire usd_pkg::usd_apb_rsp_t apb_out,
  input wire usd_pkg::usd_dma_t dma,
  input wire logic tx_take,
  input wire logic tx_shift_busy,
  input wire usd_pkg::usd_tx_t tx_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic st_rd;
  logic rh_rd;
  logic thr_wr;
  assign st_rd = apb_out.pready && !apb_in.pwrite && apb_in.paddr == `USD_OFF_STATUS;
  assign rh_rd = apb_out.pready && !apb_in.pwrite && apb_in.paddr == `USD_OFF_RHR;
  assign thr_wr = apb_out.pready && apb_in.pwrite && apb_in.paddr == `USD_OFF_THR;
  a_dma_end_live: assert property (st_rd |->
    apb_out.prdata[4:3] == $past({dma.tx_end, dma.rx_end}))
    else $error("dma end bits differ");
  a_dma_buf_mirror: assert property (st_rd |->
    apb_out.prdata[12:11] == $past({dma.rx_buf_full, dma.tx_buf_empty}))
    else $error("dma buffer bits differ");
  a_status_rsvd_zero: assert property (st_rd |->
    apb_out.prdata[31:25] == 7'h00 && apb_out.prdata[15:14] == 2'h0)
    else $error("status reserved bits set");
  a_rhr_rsvd_zero: assert property (rh_rd |->
    apb_out.prdata[31:16] == 16'h0000 && apb_out.prdata[14:9] == 6'h00)
    else $error("receive reserved bits set");
  a_unmapped_zero: assert property (apb_out.pslverr |->
    apb_out.pready && apb_out.prdata == 32'h00000000)
    else $error("error response carries data");
  a_take_clears: assert property (tx_out.valid && tx_take && !thr_wr |=>
    !tx_out.valid)
    else $error("held char stays after take");
  a_tx_ready_flag_held: assert property (st_rd && $past(tx_out.valid || tx_out.break_req) |->
    !apb_out.prdata[1])
    else $error("tx ready while holding");
  a_tx_empty_flag_busy: assert property (st_rd && $past(tx_out.valid || tx_shift_busy) |->
    !apb_out.prdata[9])
    else $error("tx empty while busy");
  c_status_read: cover property (st_rd);
  c_tx_take: cover property (tx_out.valid && tx_take);
  c_slave_error: cover property (apb_out.pslverr);
endmodule : usd_core_checker

bind usd_core usd_core_checker i_chk (.core_clk(core_clk), .rst_n(rst_n), .apb_in(apb_in),
  .apb_out(apb_out), .dma(dma), .tx_take(tx_take), .tx_shift_busy(tx_shift_busy),
  .tx_out(tx_out));

/* dv/usd_line_model.sv */
// Purpose: Line engine seen from the core: takes held characters and finishes breaks.
// Assumes: lag sets how slowly the engine answers, zero meaning next cycle.
// Notes: The shifter stays busy four cycles after each take.
`timescale 1ns/1ps

module usd_line_model import usd_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire usd_pkg::usd_tx_t tx_out,
  input wire logic [3:0] lag,
  output logic tx_take,
  output logic tx_shift_busy,
  output logic tx_break_done,
  output logic [9:0] last_sent
);
  logic [3:0] cnt;
  logic [3:0] bcnt;
  logic [2:0] busy;
  assign tx_shift_busy = busy != 3'h0;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      {tx_take, tx_break_done, cnt, bcnt, busy, last_sent} <= '0;
    end else begin
      busy <= busy != 3'h0 ? busy - 3'h1 : 3'h0;
      // The pulse is dropped at once, so one held char is taken only once.
      if (tx_take) begin
        tx_take <= 1'b0;
        cnt <= 4'h0;
        busy <= 3'h4;
      end else if (tx_out.valid) begin
        cnt <= cnt + 4'h1;
        if (cnt == lag) begin
          tx_take <= 1'b1;
          last_sent <= {tx_out.sync, tx_out.chr};
        end
      end
      if (tx_break_done) begin
        tx_break_done <= 1'b0;
        bcnt <= 4'h0;
      end else if (tx_out.break_req) begin
        bcnt <= bcnt + 4'h1;
        tx_break_done <= bcnt == lag;
      end
    end
  end
endmodule : usd_line_model

/* dv/usd_status_data_baud_timeout_tb_top.sv */
// Purpose: Directed tests of status, holding, baud and time-out logic over APB.
// Assumes: pready comes one cycle after setup; the master still waits for it.
// Notes: Line events are driven here; the line model answers the transmit side.
`timescale 1ns/1ps
`include "usd_cfg.svh"

module usart_status_data_baud_timeout_tb_top;
  import usd_pkg::*;
  logic core_clk, rst_n, tx_take, tx_shift_busy, tx_break_done, baud_tick, rx_en, tx_en, err;
  usd_apb_req_t req;
  usd_apb_rsp_t rsp;
  usd_rx_evt_t rx_evt;
  usd_dma_t dma;
  usd_tx_t tx_out;
  logic [3:0] modem_pins;
  logic [9:0] last_sent;
  logic [31:0] q;
  int failures, n_tests, ticks;
  usd_core i_dut (.core_clk(core_clk), .rst_n(rst_n), .apb_in(req), .apb_out(rsp),
    .rx_evt(rx_evt), .dma(dma), .modem_pins(modem_pins), .tx_take(tx_take),
    .tx_shift_busy(tx_shift_busy), .tx_break_done(tx_break_done), .tx_out(tx_out),
    .baud_tick(baud_tick), .rx_enabled(rx_en), .tx_enabled(tx_en));
  usd_line_model i_line (.core_clk(core_clk), .rst_n(rst_n), .tx_out(tx_out), .lag(4'h6),
    .tx_take(tx_take), .tx_shift_busy(tx_shift_busy), .tx_break_done(tx_break_done),
    .last_sent(last_sent));
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) if (baud_tick === 1'b1) ticks <= ticks + 1;
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (rsp.pready !== 1'b1) begin
      failures++;
      summarize();
    end
    q = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read", e, q & m);
  endtask : rdm
  task automatic ev(input usd_rx_evt_t e);
    @(posedge core_clk);
    rx_evt <= e;
    @(posedge core_clk);
    rx_evt <= '0;
  endtask : ev
  task automatic t_reset;
    rdm(`USD_OFF_STATUS, 32'hffffffff, 32'h0);
    rdm(`USD_OFF_BRGR, 32'hffffffff, 32'h0);
    rdm(`USD_OFF_RATIO, 32'hffffffff, 32'h174);
    apb(1'b1, `USD_OFF_STATUS, 32'hffffffff);
    rdm(`USD_OFF_STATUS, 32'hffffffff, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("t_reset done");
  endtask : t_reset
  task automatic t_rx;
    apb(1'b1, `USD_OFF_CTRL, 32'h10);
    @(posedge core_clk);
    chk("rx enabled", 32'h1, {31'h0, rx_en});
    ev('{char_valid: 1'b1, chr: 9'h1a5, sync: 1'b1, default: 1'b0});
    rdm(`USD_OFF_STATUS, 32'h21, 32'h1);
    rdm(`USD_OFF_RHR, 32'hffffffff, 32'h81a5);
    rdm(`USD_OFF_STATUS, 32'h1, 32'h0);
    ev('{char_valid: 1'b1, chr: 9'h011, default: 1'b0});
    ev('{char_valid: 1'b1, chr: 9'h022, default: 1'b0});
    rdm(`USD_OFF_STATUS, 32'h21, 32'h21);
    apb(1'b1, `USD_OFF_CTRL, 32'h100);
    rdm(`USD_OFF_STATUS, 32'h20, 32'h0);
    apb(1'b1, `USD_OFF_CTRL, 32'h20);
    rdm(`USD_OFF_STATUS, 32'h1, 32'h0);
    chk("rx enabled", 32'h0, {31'h0, rx_en});
    $display("t_rx done");
  endtask : t_rx
  task automatic t_err;
    ev('{parity_err: 1'b1, frame_err: 1'b1, brk: 1'b1, man_err: 1'b1, no_ack_flag: 1'b1,
      retry_limit: 1'b1, overrun: 1'b1, default: 1'b0});
    rdm(`USD_OFF_STATUS, 32'h010024e4, 32'h010024e4);
    apb(1'b1, `USD_OFF_CTRL, 32'h100);
    rdm(`USD_OFF_STATUS, 32'h010024e4, 32'h2400);
    apb(1'b1, `USD_OFF_CTRL, 32'h6000);
    rdm(`USD_OFF_STATUS, 32'h2400, 32'h0);
    $display("t_err done");
  endtask : t_err
  task automatic t_tx;
    apb(1'b1, `USD_OFF_CTRL, 32'h40);
    rdm(`USD_OFF_STATUS, 32'h202, 32'h202);
    chk("tx enabled", 32'h1, {31'h0, tx_en});
    apb(1'b1, `USD_OFF_THR, 32'h81c3);
    rdm(`USD_OFF_STATUS, 32'h202, 32'h0);
    repeat (20) @(posedge core_clk);
    chk("sent char", 32'h3c3, {22'h0, last_sent});
    rdm(`USD_OFF_STATUS, 32'h202, 32'h202);
    apb(1'b1, `USD_OFF_CTRL, 32'h200);
    rdm(`USD_OFF_STATUS, 32'h2, 32'h0);
    repeat (20) @(posedge core_clk);
    rdm(`USD_OFF_STATUS, 32'h2, 32'h2);
    apb(1'b1, `USD_OFF_CTRL, 32'h80);
    rdm(`USD_OFF_STATUS, 32'h202, 32'h0);
    chk("tx enabled", 32'h0, {31'h0, tx_en});
    $display("t_tx done");
  endtask : t_tx
  task automatic t_lines;
    dma <= '{1'b1, 1'b1, 1'b1, 1'b1};
    rdm(`USD_OFF_STATUS, 32'h1818, 32'h1818);
    dma <= '0;
    rdm(`USD_OFF_STATUS, 32'h1818, 32'h0);
    modem_pins <= 4'h4;
    repeat (5) @(posedge core_clk);
    rdm(`USD_OFF_STATUS, 32'h00ff0000, 32'h00440000);
    rdm(`USD_OFF_STATUS, 32'h00ff0000, 32'h00400000);
    $display("t_lines done");
  endtask : t_lines
  task automatic count(input int cyc, input int e);
    int t0;
    repeat (20) @(posedge core_clk);
    t0 = ticks;
    repeat (cyc) @(posedge core_clk);
    chk("bit ticks", e, ticks - t0);
  endtask : count
  task automatic t_baud;
    apb(1'b1, `USD_OFF_MODE, 32'h100);
    apb(1'b1, `USD_OFF_BRGR, 32'h2);
    count(40, 20);
    apb(1'b1, `USD_OFF_RTOR, 32'h3);
    apb(1'b1, `USD_OFF_CTRL, 32'h800);
    rdm(`USD_OFF_STATUS, 32'h100, 32'h0);
    repeat (20) @(posedge core_clk);
    rdm(`USD_OFF_STATUS, 32'h100, 32'h100);
    apb(1'b1, `USD_OFF_RTOR, 32'h0);
    rdm(`USD_OFF_STATUS, 32'h100, 32'h0);
    apb(1'b1, `USD_OFF_BRGR, 32'h40002);
    count(50, 20);
    apb(1'b1, `USD_OFF_BRGR, 32'h0);
    count(40, 0);
    apb(1'b1, `USD_OFF_MODE, 32'h80000);
    apb(1'b1, `USD_OFF_BRGR, 32'h1);
    count(80, 10);
    apb(1'b1, `USD_OFF_MODE, 32'h1);
    apb(1'b1, `USD_OFF_RATIO, 32'h0);
    count(40, 0);
    apb(1'b1, `USD_OFF_RATIO, 32'h3);
    count(60, 20);
    apb(1'b1, `USD_OFF_MODE, 32'h0);
    count(160, 10);
    $display("t_baud done");
  endtask : t_baud
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial begin
    {core_clk, rst_n, failures, n_tests, ticks} = '0;
    {req, rx_evt, dma, modem_pins} = '0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_rx();
    t_err();
    t_tx();
    t_lines();
    t_baud();
    summarize();
  end
  // Whole run is under a thousand cycles; twenty thousand cycles means a hang.
  initial begin
    #400000;
    failures++;
    summarize();
  end
endmodule : usart_status_data_baud_timeout_tb_top

/* hw/usd_cfg.svh */
// Purpose: Offsets, field positions and reset values of the serial channel core.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes: Definitions only.
`ifndef USD_CFG_SVH
`define USD_CFG_SVH
`define USD_OFF_CTRL 8'h00
`define USD_OFF_MODE 8'h04
`define USD_OFF_STATUS 8'h14
`define USD_OFF_RHR 8'h18
`define USD_OFF_THR 8'h1c
`define USD_OFF_BRGR 8'h20
`define USD_OFF_RTOR 8'h24
`define USD_OFF_RATIO 8'h40
`define USD_CTL_RX_EN 4
`define USD_CTL_RX_DIS 5
`define USD_CTL_TX_EN 6
`define USD_CTL_TX_DIS 7
`define USD_CTL_RST_STA 8
`define USD_CTL_STT_BRK 9
`define USD_CTL_STT_TO 11
`define USD_CTL_CLR_RETRY 13
`define USD_CTL_CLR_NO_ACK_FLAG 14
`define USD_MODE_SMART 0
`define USD_MODE_SYNC 8
`define USD_MODE_OVER 19
`define USD_SYNC_BIT 15
`define USD_FP_LSB 16
`define USD_RATIO_RST 11'h174
`define USD_PRE_NORMAL 11'h010
`define USD_PRE_HALF 11'h008
`define USD_PRE_SYNC 11'h001
`endif

/* hw/usd_core.sv */
// Purpose: Status, holding, baud divider and receive time-out core of a serial channel.
// Assumes: Line engine events arrive on core_clk; modem lines are asynchronous pins.
// Notes: APB slave answering with pready one cycle after the setup cycle.
// Operation
// - Receive ready set on character, cleared by read.
// - Transmit ready low while holding, breaking, disabled.
// - Break event sticky until reset-status command.
// - DMA end-of-transfer levels shown live.
// - DMA buffer empty and full mirrored.
// - Overrun flag sticky until reset-status.
// - Framing error sticky until reset-status.
// - Parity error sticky until reset-status.
// - Time-out flag after start, clear when zero.
// - Transmit empty needs both holding and shifter empty.
// - Retry limit flag held until its clear.
// - No-ack flag held until its clear.
// - Modem change flags, cleared on status read.
// - Modem line images in bits 20 to 23.
// - Manchester error sticky until reset-status.
// - Receive holding gives character and sync type.
// - Transmit holding takes character and sync type.
// - Divider zero stops baud clock.
// - Baud prescale sixteen, eight, one or ratio.
// - Fractional part adds eighths of a period.
// - Time-out of value bit periods, zero disables.
// - Smartcard ratio zero gives no baud.
`timescale 1ns/1ps
`include "usd_cfg.svh"

module usd_core (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire usd_pkg::usd_apb_req_t apb_in,
  output usd_pkg::usd_apb_rsp_t apb_out,
  input wire usd_pkg::usd_rx_evt_t rx_evt,
  input wire usd_pkg::usd_dma_t dma,
  input wire logic [3:0] modem_pins,
  input wire logic tx_take,
  input wire logic tx_shift_busy,
  input wire logic tx_break_done,
  output usd_pkg::usd_tx_t tx_out,
  output logic baud_tick,
  output logic rx_enabled,
  output logic tx_enabled
);
  import usd_pkg::*;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic rx_en;
    logic tx_en;
    logic over;
    logic sync;
    logic smart;
    logic [15:0] cd;
    logic [2:0] fp;
    logic [15:0] to_val;
    logic [10:0] ratio;
    logic rx_rdy;
    logic [8:0] rx_chr;
    logic rx_syn;
    logic thr_full;
    logic [8:0] thr_chr;
    logic thr_syn;
    logic brk_pend;
    logic brk_f;
    logic ovr_f;
    logic frm_f;
    logic par_f;
    logic man_f;
    logic no_ack_flag_f;
    logic iter_f;
    logic tmo_f;
    logic [3:0] chg;
    logic [3:0] mdm_meta;
    logic [3:0] mdm_sync;
    logic [3:0] mdm_prev;
    logic [15:0] div_cnt;
    logic [2:0] frac_acc;
    logic extra;
    logic [10:0] pre_cnt;
    logic tick;
    logic [15:0] to_cnt;
    logic to_run;
    logic tx_valid;
  } usd_state_t;

  usd_state_t st_reg;
  usd_state_t st_next;

  // Selects the prescale mode from the mode bits.
  function automatic usd_baud_t baud_mode(input logic smart, input logic sync,
                                          input logic over);
    if (smart) begin
      return BAUD_SMART;
    end else if (sync) begin
      return BAUD_SYNC;
    end else if (over) begin
      return BAUD_HALF;
    end else begin
      return BAUD_NORMAL;
    end
  endfunction : baud_mode

  // Number of divided clock ticks that make one bit period.
  function automatic logic [10:0] pre_len(input usd_baud_t m, input logic [10:0] ratio);
    case (m)
      BAUD_NORMAL: begin
        return `USD_PRE_NORMAL;
      end
      BAUD_HALF: begin
        return `USD_PRE_HALF;
      end
      BAUD_SYNC: begin
        return `USD_PRE_SYNC;
      end
      default: begin
        return ratio;
      end
    endcase
  endfunction : pre_len

  // Status word image, shared by the read path.
  function automatic logic [31:0] status_word(input usd_state_t s, input usd_dma_t d);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[0] = s.rx_rdy & s.rx_en;
    w[1] = s.tx_en & ~s.thr_full & ~s.brk_pend;
    w[2] = s.brk_f;
    w[3] = d.rx_end;
    w[4] = d.tx_end;
    w[5] = s.ovr_f;
    w[6] = s.frm_f;
    w[7] = s.par_f;
    w[8] = s.tmo_f & (s.to_val != 16'h0000);
    w[9] = s.tx_en & ~s.thr_full & ~tx_shift_busy;
    w[10] = s.iter_f;
    w[11] = d.tx_buf_empty;
    w[12] = d.rx_buf_full;
    w[13] = s.no_ack_flag_f;
    w[19:16] = s.chg | (s.mdm_sync ^ s.mdm_prev);
    w[23:20] = s.mdm_sync;
    w[24] = s.man_f;
    return w;
  endfunction : status_word

  always_comb begin
    logic setup;
    logic acc;
    logic wr;
    logic rd;
    logic [31:0] wd;
    logic [3:0] fsum;
    logic [10:0] plen;
    logic dtick;
    st_next = st_reg;
    setup = apb_in.psel & ~apb_in.penable;
    acc = apb_in.psel & apb_in.penable & st_reg.pready;
    wr = acc & apb_in.pwrite;
    rd = acc & ~apb_in.pwrite;
    wd = apb_in.pwdata;
    fsum = 4'h0;
    dtick = 1'b0;
    plen = pre_len(baud_mode(st_reg.smart, st_reg.sync, st_reg.over), st_reg.ratio);

    // Response is prepared in the setup cycle so pready rises in the access phase.
    st_next.pready = setup;
    st_next.pslverr = 1'b0;
    st_next.prdata = 32'h0000_0000;
    if (setup) begin
      case (apb_in.paddr)
        `USD_OFF_CTRL, `USD_OFF_THR: begin
          st_next.prdata = 32'h0000_0000;
        end
        `USD_OFF_MODE: begin
          st_next.prdata[`USD_MODE_SMART] = st_reg.smart;
          st_next.prdata[`USD_MODE_SYNC] = st_reg.sync;
          st_next.prdata[`USD_MODE_OVER] = st_reg.over;
        end
        `USD_OFF_STATUS: begin
          st_next.prdata = status_word(st_reg, dma);
        end
        `USD_OFF_RHR: begin
          if (rx_evt.char_valid && st_reg.rx_en) begin
            st_next.prdata[8:0] = rx_evt.chr;
            st_next.prdata[`USD_SYNC_BIT] = rx_evt.sync;
          end else begin
            st_next.prdata[8:0] = st_reg.rx_chr;
            st_next.prdata[`USD_SYNC_BIT] = st_reg.rx_syn;
          end
        end
        `USD_OFF_BRGR: begin
          st_next.prdata[15:0] = st_reg.cd;
          st_next.prdata[`USD_FP_LSB +: 3] = st_reg.fp;
        end
        `USD_OFF_RTOR: begin
          st_next.prdata[15:0] = st_reg.to_val;
        end
        `USD_OFF_RATIO: begin
          st_next.prdata[10:0] = st_reg.ratio;
        end
        default: begin
          st_next.pslverr = 1'b1;
        end
      endcase
    end

    // Software writes; status and receive holding have no write case.
    if (wr) begin
      case (apb_in.paddr)
        `USD_OFF_CTRL: begin
          if (wd[`USD_CTL_RX_EN]) begin
            st_next.rx_en = 1'b1;
          end
          if (wd[`USD_CTL_RX_DIS]) begin
            st_next.rx_en = 1'b0;
          end
          if (wd[`USD_CTL_TX_EN]) begin
            st_next.tx_en = 1'b1;
          end
          if (wd[`USD_CTL_TX_DIS]) begin
            st_next.tx_en = 1'b0;
          end
          if (wd[`USD_CTL_RST_STA]) begin
            st_next.brk_f = 1'b0;
            st_next.ovr_f = 1'b0;
            st_next.frm_f = 1'b0;
            st_next.par_f = 1'b0;
            st_next.man_f = 1'b0;
          end
          if (wd[`USD_CTL_CLR_RETRY]) begin
            st_next.iter_f = 1'b0;
          end
          if (wd[`USD_CTL_CLR_NO_ACK_FLAG]) begin
            st_next.no_ack_flag_f = 1'b0;
          end
        end
        `USD_OFF_MODE: begin
          st_next.smart = wd[`USD_MODE_SMART];
          st_next.sync = wd[`USD_MODE_SYNC];
          st_next.over = wd[`USD_MODE_OVER];
        end
        `USD_OFF_THR: begin
          st_next.thr_chr = wd[8:0];
          st_next.thr_syn = wd[`USD_SYNC_BIT];
          st_next.thr_full = 1'b1;
        end
        `USD_OFF_BRGR: begin
          st_next.cd = wd[15:0];
          st_next.fp = wd[`USD_FP_LSB +: 3];
        end
        `USD_OFF_RTOR: begin
          st_next.to_val = wd[15:0];
          if (wd[15:0] == 16'h0000) begin
            st_next.to_run = 1'b0;
          end
        end
        `USD_OFF_RATIO: begin
          st_next.ratio = wd[10:0];
        end
        default: begin
          st_next.pslverr = 1'b0;
        end
      endcase
    end

    // Read side effects take place at the completing edge only.
    if (rd && apb_in.paddr == `USD_OFF_RHR) begin
      st_next.rx_rdy = 1'b0;
    end
    if (rd && apb_in.paddr == `USD_OFF_STATUS) begin
      st_next.chg = 4'h0;
    end

    // Modem pins pass two flip-flops; edges are seen between sync and prev.
    st_next.mdm_meta = modem_pins;
    st_next.mdm_sync = st_reg.mdm_meta;
    st_next.mdm_prev = st_reg.mdm_sync;
    st_next.chg = st_next.chg | (st_reg.mdm_sync ^ st_reg.mdm_prev);

    // Line events are applied after the clears so an event in the clearing cycle wins.
    if (rx_evt.char_valid && st_reg.rx_en) begin
      if (st_next.rx_rdy) begin
        st_next.ovr_f = 1'b1;
      end
      st_next.rx_rdy = 1'b1;
      st_next.rx_chr = rx_evt.chr;
      st_next.rx_syn = rx_evt.sync;
      if (st_reg.to_run) begin
        st_next.to_cnt = st_reg.to_val;
      end
    end
    if (rx_evt.overrun) begin
      st_next.ovr_f = 1'b1;
    end
    if (rx_evt.brk) begin
      st_next.brk_f = 1'b1;
    end
    if (rx_evt.frame_err) begin
      st_next.frm_f = 1'b1;
    end
    if (rx_evt.parity_err) begin
      st_next.par_f = 1'b1;
    end
    if (rx_evt.man_err) begin
      st_next.man_f = 1'b1;
    end
    if (rx_evt.no_ack_flag) begin
      st_next.no_ack_flag_f = 1'b1;
    end
    if (rx_evt.retry_limit) begin
      st_next.iter_f = 1'b1;
    end

    // Transmit side: the engine takes the held character with tx_take.
    if (st_reg.tx_valid && tx_take) begin
      st_next.thr_full = 1'b0;
    end
    if (tx_break_done) begin
      st_next.brk_pend = 1'b0;
    end
    if (wr && apb_in.paddr == `USD_OFF_CTRL && wd[`USD_CTL_STT_BRK]) begin
      st_next.brk_pend = 1'b1;
    end
    if (wr && apb_in.paddr == `USD_OFF_THR) begin
      st_next.thr_full = 1'b1;
    end
    st_next.tx_valid = st_next.thr_full & st_next.tx_en & ~st_next.brk_pend;

    // Divider: period is cd cycles plus one extra cycle whenever the eighths carry.
    if (st_reg.cd == 16'h0000) begin
      st_next.div_cnt = 16'h0000;
      st_next.frac_acc = 3'h0;
      st_next.extra = 1'b0;
    end else if (st_reg.div_cnt >= st_reg.cd - 16'h0001 + {15'h0000, st_reg.extra}) begin
      dtick = 1'b1;
      st_next.div_cnt = 16'h0000;
      fsum = {1'b0, st_reg.frac_acc} + {1'b0, st_reg.fp};
      st_next.frac_acc = fsum[2:0];
      st_next.extra = fsum[3];
    end else begin
      st_next.div_cnt = st_reg.div_cnt + 16'h0001;
    end

    // Prescale to bit period; a zero ratio in smartcard mode never ticks.
    st_next.tick = 1'b0;
    if (plen == 11'h000) begin
      st_next.pre_cnt = 11'h000;
    end else if (dtick) begin
      if (st_reg.pre_cnt >= plen - 11'h001) begin
        st_next.pre_cnt = 11'h000;
        st_next.tick = 1'b1;
      end else begin
        st_next.pre_cnt = st_reg.pre_cnt + 11'h001;
      end
    end

    // Time-out counts bit periods after a start command.
    if (st_reg.to_run && st_reg.tick && !(rx_evt.char_valid && st_reg.rx_en)) begin
      if (st_reg.to_cnt <= 16'h0001) begin
        st_next.to_run = 1'b0;
        st_next.tmo_f = 1'b1;
      end else begin
        st_next.to_cnt = st_reg.to_cnt - 16'h0001;
      end
    end
    if (wr && apb_in.paddr == `USD_OFF_CTRL && wd[`USD_CTL_STT_TO]) begin
      st_next.tmo_f = 1'b0;
      st_next.to_cnt = st_next.to_val;
      st_next.to_run = (st_next.to_val != 16'h0000);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.ratio <= `USD_RATIO_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs are taken straight from the state register.
  assign apb_out = '{pready: st_reg.pready, pslverr: st_reg.pslverr, prdata: st_reg.prdata};
  assign tx_out = '{valid: st_reg.tx_valid, chr: st_reg.thr_chr, sync: st_reg.thr_syn,
                    break_req: st_reg.brk_pend};
  assign baud_tick = st_reg.tick;
  assign rx_enabled = st_reg.rx_en;
  assign tx_enabled = st_reg.tx_en;

endmodule : usd_core

/* hw/usd_pkg.sv */
// Purpose: Types shared by the serial channel core and its bench.
// Assumes: Nothing beyond SystemVerilog packed types.
// Notes: Numbers live in usd_cfg.svh.
package usd_pkg;
  typedef enum logic [1:0] {BAUD_NORMAL, BAUD_HALF, BAUD_SYNC, BAUD_SMART} usd_baud_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } usd_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } usd_apb_rsp_t;
  typedef struct packed {
    logic char_valid;
    logic [8:0] chr;
    logic sync;
    logic parity_err;
    logic frame_err;
    logic overrun;
    logic brk;
    logic man_err;
    logic no_ack_flag;
    logic retry_limit;
  } usd_rx_evt_t;
  typedef struct packed {
    logic rx_end;
    logic tx_end;
    logic tx_buf_empty;
    logic rx_buf_full;
  } usd_dma_t;
  typedef struct packed {
    logic valid;
    logic [8:0] chr;
    logic sync;
    logic break_req;
  } usd_tx_t;
endpackage : usd_pkg
